// ---- crbt_defines.svh ----
// Register indices, field positions, reset values and tick divisors for the timer
`ifndef CRBT_DEFINES_SVH
`define CRBT_DEFINES_SVH
// Register indices; byte address is four times the index
`define CRBT_IDX_CTRL 8'hC8
`define CRBT_IDX_MASK 8'hC9
`define CRBT_IDX_CAPL 8'hCA
`define CRBT_IDX_CAPH 8'hCB
`define CRBT_IDX_CNTL 8'hCC
`define CRBT_IDX_CNTH 8'hCD
`define CRBT_IDX_CFG 8'hCE
`define CRBT_IDX_STAT 8'hCF
// Control register fields
`define CRBT_B_OVF 7
`define CRBT_B_EXT 6
`define CRBT_B_RXSEL 5
`define CRBT_B_TXSEL 4
`define CRBT_B_EXEN 3
`define CRBT_B_RUN 2
`define CRBT_B_CTS 1
`define CRBT_B_CPRL 0
// Configuration register fields
`define CRBT_B_SPEED 0
`define CRBT_B_IRQEN 1
// Status and mask fields
`define CRBT_S_OVF 0
`define CRBT_S_EXT 1
`define CRBT_S_CAP 2
// Reset values
`define CRBT_RST_BYTE 8'h00
`define CRBT_RST_STAT 3'h0
// Internal tick divisors, slow and fast timer speed
`define CRBT_DIV_SLOW 4'hC
`define CRBT_DIV_FAST 4'h4
// Bus answers
`define CRBT_RESP_OKAY 2'h0
`define CRBT_RESP_SLVERR 2'h2
`endif

// ---- crbt_pkg.sv ----
// Types shared by the capture/reload/baud timer
package crbt_pkg;
  // Counting mode, Gray coded along reload, capture, baud
  typedef enum logic [1:0] {
    CRBT_MODE_RELOAD = 2'h0,
    CRBT_MODE_CAPTURE = 2'h1,
    CRBT_MODE_BAUD = 2'h3
  } crbt_mode_e;
  typedef logic [7:0] crbt_byte_t;
endpackage : crbt_pkg

// ---- crbt_serial_partner.sv ----
// Far-side model: serial port baud sinks, the other timer and the external pins
module crbt_serial_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  output logic count_input_pin,
  output logic trigger_pin,
  output logic timer1_overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  int rx_ticks = 0;
  int tx_ticks = 0;
  // Pins rest high, so only commanded falls count as edges
  initial
  begin
    count_input_pin = 1'b1;
    trigger_pin = 1'b1;
    timer1_overflow = 1'b0;
  end
  // Serial port counts each one-cycle baud pulse it is handed
  always @(posedge clk)
  begin
    if (rst_n && rx_baud_tick === 1'b1)
      rx_ticks++;
    if (rst_n && tx_baud_tick === 1'b1)
      tx_ticks++;
  end
  // Select 0: count pin fall, 1: trigger fall, 2: other timer overflow
  task automatic pulse(input int sel);
    @(posedge clk);
    count_input_pin <= (sel != 0);
    trigger_pin <= (sel != 1);
    timer1_overflow <= (sel == 2);
    @(posedge clk);
    timer1_overflow <= 1'b0; // Overflow lasts a single cycle
    @(posedge clk);
    count_input_pin <= 1'b1;
    trigger_pin <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : pulse
endmodule : crbt_serial_partner

// ---- crbt_timer.sv ----
// 16-bit capture/reload/baud timer with AXI4-Lite register slave
// Summary of operation
// - Rollover from FFFFh sets overflow flag, sticky
// - Overflow flag set only when both selects zero
// - Software overflow flag write raises timer interrupt
// - Trigger falling edge sets external flag when enabled
// - Software external flag write raises timer interrupt
// - Receive select picks timer1 or this overflow
// - Transmit select picks timer1 or this overflow
// - Either select enters baud mode, clock/2
// - Trigger edges reload/capture only when enabled, not baud
// - Run bit starts counting; halt stops ticks, enabled trigger edges still reload
// - Timer select: internal ticks or count pin
// - Baud mode advances every two clocks
// - Baud mode forces auto-reload, ignores capture select
// - Reload mode: reload on overflow or enabled trigger edge
// - Capture mode: enabled trigger edge captures count
// - Capture bytes take count; supply reload value
// - Count held in readable, writable low/high bytes
`include "crbt_defines.svh"
module crbt_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  input wire logic timer1_overflow,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic timer_irq,
  output logic irq
);

  // Decode a byte address to a register index; misses give 8'h00
  function automatic logic [7:0] crbt_index(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[11:10] != 2'h0 || addr[1:0] != 2'h0 || idx < `CRBT_IDX_CTRL
        || idx > `CRBT_IDX_STAT)
      crbt_index = 8'h00;
    else
      crbt_index = idx;
  endfunction : crbt_index

  crbt_pkg::crbt_byte_t ctrl_reg, cap_lo_reg, cap_hi_reg, cnt_lo_reg, cnt_hi_reg;
  logic [1:0] cfg_reg;
  logic [2:0] stat_reg, mask_reg, events;
  logic [11:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic [3:0] pre_cnt_reg;
  logic w_lane_reg, div2_reg, cnt_pin_reg, trig_pin_reg;

  // Write channel: address and data taken in either order
  logic wr_go;
  logic [7:0] wr_idx, wr_byte;
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = crbt_index(aw_addr_reg);
  assign wr_byte = w_data_reg;

  function automatic logic crbt_wr(input logic go, input logic lane,
                                   input logic [7:0] idx, input logic [7:0] tgt);
    crbt_wr = go && lane && idx == tgt;
  endfunction : crbt_wr

  logic wr_ctrl, wr_capl, wr_caph, wr_cntl, wr_cnth;
  assign wr_ctrl = crbt_wr(wr_go, w_lane_reg, wr_idx, `CRBT_IDX_CTRL);
  assign wr_capl = crbt_wr(wr_go, w_lane_reg, wr_idx, `CRBT_IDX_CAPL);
  assign wr_caph = crbt_wr(wr_go, w_lane_reg, wr_idx, `CRBT_IDX_CAPH);
  assign wr_cntl = crbt_wr(wr_go, w_lane_reg, wr_idx, `CRBT_IDX_CNTL);
  assign wr_cnth = crbt_wr(wr_go, w_lane_reg, wr_idx, `CRBT_IDX_CNTH);

  // Write handshake state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRBT_RESP_OKAY;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_idx == 8'h00) ? `CRBT_RESP_SLVERR : `CRBT_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Mode and tick generation
  crbt_pkg::crbt_mode_e mode;
  logic baud, run, tick, ovf, cnt_fall, trig_fall, ext_evt, ext_act;
  logic do_reload, do_capture, pre_slow, pre_fast, rd_go;
  logic [15:0] count, cap;
  assign count = {cnt_hi_reg, cnt_lo_reg};
  assign cap = {cap_hi_reg, cap_lo_reg};
  assign baud = ctrl_reg[`CRBT_B_RXSEL] | ctrl_reg[`CRBT_B_TXSEL];
  assign run = ctrl_reg[`CRBT_B_RUN];
  assign cnt_fall = cnt_pin_reg && !count_input_pin;
  assign trig_fall = trig_pin_reg && !trigger_pin;
  assign pre_slow = pre_cnt_reg == `CRBT_DIV_SLOW - 4'h1;
  assign pre_fast = pre_cnt_reg[1:0] == 2'h3;
  always_comb
  begin
    if (baud)
      mode = crbt_pkg::CRBT_MODE_BAUD;
    else if (ctrl_reg[`CRBT_B_CPRL])
      mode = crbt_pkg::CRBT_MODE_CAPTURE;
    else
      mode = crbt_pkg::CRBT_MODE_RELOAD;
  end

  // Tick source: baud half rate, count pin, or internal prescale
  always_comb
  begin
    tick = 1'b0;
    if (run)
    begin
      if (baud)
        tick = div2_reg;
      else if (ctrl_reg[`CRBT_B_CTS])
        tick = cnt_fall;
      else
        tick = cfg_reg[`CRBT_B_SPEED] ? pre_fast : pre_slow;
    end
  end

  assign ovf = tick && count == 16'hFFFF;
  assign ext_evt = ctrl_reg[`CRBT_B_EXEN] && trig_fall;
  assign ext_act = ext_evt && !baud;

  // Reload and capture decisions per mode
  always_comb
  begin
    do_reload = 1'b0;
    do_capture = 1'b0;
    case (mode)
      crbt_pkg::CRBT_MODE_BAUD: do_reload = ovf;
      crbt_pkg::CRBT_MODE_RELOAD: do_reload = ovf || ext_act;
      crbt_pkg::CRBT_MODE_CAPTURE: do_capture = ext_act;
      default: do_reload = 1'b0;
    endcase
  end

  // Prescaler, half-rate divider and pin history
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_reg <= 4'h0;
      div2_reg <= 1'b0;
      cnt_pin_reg <= 1'b0;
      trig_pin_reg <= 1'b0;
    end
    else
    begin
      pre_cnt_reg <= pre_slow ? 4'h0 : pre_cnt_reg + 4'h1;
      div2_reg <= !div2_reg;
      cnt_pin_reg <= count_input_pin;
      trig_pin_reg <= trigger_pin;
    end
  end

  // Count bytes: software write wins over its own byte's update
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_lo_reg <= `CRBT_RST_BYTE;
      cnt_hi_reg <= `CRBT_RST_BYTE;
    end
    else
    begin
      if (do_reload)
      begin
        cnt_lo_reg <= cap_lo_reg;
        cnt_hi_reg <= cap_hi_reg;
      end
      else if (tick)
      begin
        cnt_lo_reg <= count[7:0] + 8'h01;
        cnt_hi_reg <= (count[7:0] == 8'hFF) ? count[15:8] + 8'h01 : count[15:8];
      end
      if (wr_cntl)
        cnt_lo_reg <= wr_byte;
      if (wr_cnth)
        cnt_hi_reg <= wr_byte;
    end
  end

  // Capture/reload bytes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_lo_reg <= `CRBT_RST_BYTE;
      cap_hi_reg <= `CRBT_RST_BYTE;
    end
    else
    begin
      if (do_capture)
      begin
        cap_lo_reg <= cnt_lo_reg;
        cap_hi_reg <= cnt_hi_reg;
      end
      if (wr_capl)
        cap_lo_reg <= wr_byte;
      if (wr_caph)
        cap_hi_reg <= wr_byte;
    end
  end

  // Control register; hardware set beats a software clear of a flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= `CRBT_RST_BYTE;
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= wr_byte;
      if (ovf && !baud)
        ctrl_reg[`CRBT_B_OVF] <= 1'b1;
      if (ext_evt)
        ctrl_reg[`CRBT_B_EXT] <= 1'b1;
    end
  end

  // Configuration and mask registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg <= 2'h0;
      mask_reg <= `CRBT_RST_STAT;
    end
    else
    begin
      if (crbt_wr(wr_go, w_lane_reg, wr_idx, `CRBT_IDX_CFG))
        cfg_reg <= wr_byte[1:0];
      if (crbt_wr(wr_go, w_lane_reg, wr_idx, `CRBT_IDX_MASK))
        mask_reg <= wr_byte[2:0];
    end
  end

  // Read channel: one-cycle answer, status cleared by its read
  logic [7:0] rd_idx, rd_val;
  assign rd_idx = crbt_index(s_axi_araddr);
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    case (rd_idx)
      `CRBT_IDX_CTRL: rd_val = ctrl_reg;
      `CRBT_IDX_MASK: rd_val = {5'h00, mask_reg};
      `CRBT_IDX_CAPL: rd_val = cap_lo_reg;
      `CRBT_IDX_CAPH: rd_val = cap_hi_reg;
      `CRBT_IDX_CNTL: rd_val = cnt_lo_reg;
      `CRBT_IDX_CNTH: rd_val = cnt_hi_reg;
      `CRBT_IDX_CFG: rd_val = {6'h00, cfg_reg};
      `CRBT_IDX_STAT: rd_val = {5'h00, stat_reg};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CRBT_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= (rd_idx == 8'h00) ? `CRBT_RESP_SLVERR : `CRBT_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Sticky event status; a new event survives a clearing read
  assign events = {do_capture, ext_evt, ovf};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_reg <= `CRBT_RST_STAT;
    else if (rd_go && rd_idx == `CRBT_IDX_STAT)
      stat_reg <= events;
    else
      stat_reg <= stat_reg | events;
  end

  // Interrupt and baud outputs, all registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
      timer_irq <= 1'b0;
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
    end
    else
    begin
      irq <= |(stat_reg & mask_reg);
      timer_irq <= cfg_reg[`CRBT_B_IRQEN]
        && (ctrl_reg[`CRBT_B_OVF] || ctrl_reg[`CRBT_B_EXT]);
      rx_baud_tick <= ctrl_reg[`CRBT_B_RXSEL] ? ovf : timer1_overflow;
      tx_baud_tick <= ctrl_reg[`CRBT_B_TXSEL] ? ovf : timer1_overflow;
    end
  end

  // Checks on the timer behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rollover;
    ovf && !baud;
  endsequence
  sequence s_reload_only;
    do_reload && !wr_cntl && !wr_cnth;
  endsequence
  a_ovf_flag_set: assert property (s_rollover |=> ctrl_reg[`CRBT_B_OVF])
    else $error("overflow flag not set on rollover");
  a_ovf_flag_baud: assert property (
    baud && ovf && !ctrl_reg[`CRBT_B_OVF] && !wr_ctrl |=> !ctrl_reg[`CRBT_B_OVF])
    else $error("overflow flag set in baud mode");
  a_ext_flag_set: assert property (ext_evt |=> ctrl_reg[`CRBT_B_EXT])
    else $error("external flag not set on trigger edge");
  a_timer_irq_raise: assert property (
    wr_ctrl && wr_byte[`CRBT_B_OVF] && cfg_reg[`CRBT_B_IRQEN] |=> ##1 timer_irq)
    else $error("overflow flag write did not raise interrupt");
  a_reload_value: assert property (s_reload_only |=> count == $past(cap))
    else $error("reload value not loaded");
  a_capture_value: assert property (
    do_capture && !wr_capl && !wr_caph |=> cap == $past(count))
    else $error("capture value wrong");
  a_halt_hold: assert property (
    !run && !do_reload && !wr_cntl && !wr_cnth |=> $stable(count))
    else $error("count changed while halted");
  a_baud_rate: assert property (
    baud && run && $past(baud && run) |-> tick != $past(tick))
    else $error("baud mode tick missing");
  a_baud_ignore: assert property (
    baud && ext_evt && !wr_capl && !wr_caph |=> $stable(cap))
    else $error("trigger acted in baud mode");
  a_rx_source: assert property (
    ctrl_reg[`CRBT_B_RXSEL] && ovf |=> rx_baud_tick)
    else $error("receive baud tick missing");
  a_tx_source: assert property (
    !ctrl_reg[`CRBT_B_TXSEL] && timer1_overflow |=> tx_baud_tick)
    else $error("transmit baud tick not from timer1");
endmodule : crbt_timer

// ---- crbt_timer_tb_top.sv ----
// Self-checking bench for the capture/reload/baud timer
`include "crbt_defines.svh"
`define CHK(nm, e, a) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      miscompares++; \
      $display("[ERR] %s expected %h seen %h", nm, e, a); \
    end \
  end
module crbt_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] i_ct = `CRBT_IDX_CTRL, i_mk = `CRBT_IDX_MASK, i_cl = `CRBT_IDX_CAPL;
  localparam logic [7:0] i_ch = `CRBT_IDX_CAPH, i_nl = `CRBT_IDX_CNTL, i_nh = `CRBT_IDX_CNTH;
  localparam logic [7:0] i_cf = `CRBT_IDX_CFG, i_st = `CRBT_IDX_STAT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd, rnd;
  logic count_input_pin, trigger_pin, timer1_overflow, rx_baud_tick, tx_baud_tick;
  logic timer_irq, irq;
  logic [15:0] v, c;
  logic [7:0] sel;
  logic [7:0] ri [7] = '{i_ct, i_mk, i_cl, i_ch, i_nl, i_cf, i_st};
  int miscompares = 0, check_count = 0, cycles = 0, seed = 81331, n, n0;

  crbt_timer uut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .count_input_pin, .trigger_pin, .timer1_overflow, .rx_baud_tick,
    .tx_baud_tick, .timer_irq, .irq);
  crbt_serial_partner u_part (.clk, .rst_n, .rx_baud_tick, .tx_baud_tick, .count_input_pin,
    .trigger_pin, .timer1_overflow);

  // 50 MHz clock
  always #10 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Hang guard, far above the thousand or so cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 50000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // One bus transfer; each channel held until its own handshake edge
  task automatic bus(input bit w, input logic [7:0] i, input logic [7:0] d);
    bit ap = w, wp = w, bp = w, arp = !w, rp = !w;
    @(posedge clk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    while (ap || wp || bp || arp || rp)
    begin
      s_axi_awvalid <= ap;
      s_axi_wvalid <= wp;
      s_axi_bready <= bp;
      s_axi_arvalid <= arp;
      s_axi_rready <= rp;
      @(posedge clk);
      if (ap && s_axi_awready) ap = 0;
      if (wp && s_axi_wready) wp = 0;
      if (arp && s_axi_arready) arp = 0;
      if (bp && s_axi_bvalid) {bp, rs} = {1'b0, s_axi_bresp};
      if (rp && s_axi_rvalid) {rp, rs, rd} = {1'b0, s_axi_rresp, s_axi_rdata};
    end
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
  endtask : bus

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask : wr

  // Read with answer code and upper zero bits checked as well
  task automatic rchk(input string nm, input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    `CHK(nm, {`CRBT_RESP_OKAY, 24'h000000, e}, {rs, rd})
  endtask : rchk

  function automatic int tk(input int k);
    return k ? u_part.tx_ticks : u_part.rx_ticks;
  endfunction : tk

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, then an unmapped place both ways
    foreach (ri[k]) rchk("reset_val", ri[k], 8'h00);
    bus(1'b0, 8'hD0, 8'h00);
    `CHK("unmapped_rd", {`CRBT_RESP_SLVERR, 32'h00000000}, {rs, rd})
    wr(8'hD0, 8'hFF);
    `CHK("unmapped_wr", `CRBT_RESP_SLVERR, rs)
    $display("test reset done");
    // Random counts: hold, ignored edge, reload edge, capture edge
    repeat (4)
    begin
      rnd = $random(seed);
      {v, c} = rnd;
      wr(i_nl, v[7:0]);
      wr(i_nh, v[15:8]);
      rchk("cnt_hi", i_nh, v[15:8]);
      repeat (20) @(posedge clk);
      rchk("halt_lo", i_nl, v[7:0]);
      wr(i_cl, c[7:0]);
      wr(i_ch, c[15:8]);
      wr(i_ct, 8'h00);
      u_part.pulse(1);
      rchk("no_reload", i_nl, v[7:0]);
      wr(i_ct, 8'h08);
      u_part.pulse(1);
      rchk("reload_lo", i_nl, c[7:0]);
      rchk("reload_hi", i_nh, c[15:8]);
      rchk("ext_flag", i_ct, 8'h48);
      wr(i_nl, v[7:0]);
      wr(i_nh, v[15:8]);
      wr(i_ct, 8'h09);
      u_part.pulse(1);
      rchk("cap_lo", i_cl, v[7:0]);
      rchk("cap_hi", i_ch, v[15:8]);
      rchk("cap_keeps", i_nl, v[7:0]);
    end
    $display("test trigger done");
    // Rollover from all ones, masked then unmasked interrupt
    wr(i_ct, 8'h00);
    wr(i_cf, 8'h03);
    wr(i_mk, 8'h00);
    bus(1'b0, i_st, 8'h00);
    wr(i_cl, 8'h00);
    wr(i_ch, c[7:0]);
    wr(i_nl, 8'hFF);
    wr(i_nh, 8'hFF);
    `CHK("irq_idle", 1'b0, timer_irq)
    wr(i_ct, 8'h04);
    n = 0;
    while (timer_irq !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("ovf_irq", 1'b1, timer_irq)
    `CHK("masked", 1'b0, irq)
    wr(i_ct, 8'h80);
    rchk("ovf_flag", i_ct, 8'h80);
    rchk("ovf_reload", i_nh, c[7:0]);
    bus(1'b0, i_nl, 8'h00);
    `CHK("ovf_low", 1'b1, rd[7:0] < 8'h10)
    wr(i_mk, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("unmasked", 1'b1, irq)
    rchk("status", i_st, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("irq_clear", 1'b0, irq)
    // Flags written by software force the timer interrupt
    for (int k = 0; k < 2; k++)
    begin
      wr(i_ct, 8'h00);
      repeat (2) @(posedge clk);
      `CHK("flag_off", 1'b0, timer_irq)
      wr(i_ct, k ? 8'h40 : 8'h80);
      repeat (2) @(posedge clk);
      `CHK("flag_force", 1'b1, timer_irq)
    end
    wr(i_cf, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("irq_disabled", 1'b0, timer_irq)
    $display("test overflow done");
    // Baud mode, receive then transmit taken from this timer
    for (int k = 0; k < 2; k++)
    begin
      sel = k ? 8'h1D : 8'h2D;
      wr(i_ct, 8'h00);
      wr(i_ch, c[15:8]);
      wr(i_nl, 8'hF0);
      wr(i_nh, 8'hFF);
      n0 = tk(k);
      wr(i_ct, sel);
      n = 0;
      while (tk(k) == n0 && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      `CHK("baud_rate", 1'b1, n >= 28 && n <= 34)
      n0 = tk(1 - k);
      u_part.pulse(2);
      `CHK("other_src", n0 + 1, tk(1 - k))
      // Enabled trigger edge must neither capture nor reload here
      u_part.pulse(1);
      rchk("baud_no_cap", i_cl, 8'h00);
      wr(i_ct, sel & 8'h30);
      rchk("no_ovf_flag", i_ct, sel & 8'h30);
      rchk("baud_reload", i_nh, c[15:8]);
    end
    $display("test baud done");
    // Count pin falls in counter mode
    rnd = $random(seed);
    n = 3 + rnd[2:0];
    wr(i_nl, 8'h00);
    wr(i_nh, 8'h00);
    wr(i_ct, 8'h06);
    repeat (n) u_part.pulse(0);
    wr(i_ct, 8'h00);
    rchk("pin_count", i_nl, n[7:0]);
    // Internal ticks at both speeds over a run of about 100 clocks
    for (int k = 0; k < 2; k++)
    begin
      wr(i_cf, k ? 8'h01 : 8'h00);
      wr(i_nl, 8'h00);
      wr(i_ct, 8'h04);
      repeat (96) @(posedge clk);
      wr(i_ct, 8'h00);
      bus(1'b0, i_nl, 8'h00);
      n = 100 / (k ? `CRBT_DIV_FAST : `CRBT_DIV_SLOW);
      `CHK("speed", 1'b1, rd[7:0] + 1 >= n && rd[7:0] <= n + 1)
    end
    $display("test counter done");
    end_of_test();
  end
endmodule : crbt_timer_tb_top
